// ===== shared/timer_pkg.sv
// package: register map, field positions, reset values and timing for the dual timer
package timer_pkg;
  // byte addresses on the ahb-lite bus, one aligned word each
  localparam logic [7:0] addr_mode_config  = 8'h00;
  localparam logic [7:0] addr_run_flag     = 8'h04;
  localparam logic [7:0] addr_first_low    = 8'h08;
  localparam logic [7:0] addr_first_high   = 8'h0c;
  localparam logic [7:0] addr_second_low   = 8'h10;
  localparam logic [7:0] addr_second_high  = 8'h14;

  // field positions inside one nibble of the mode register
  localparam int mode_lsb_pos    = 0;
  localparam int mode_msb_pos    = 1;
  localparam int counter_sel_pos = 2;
  localparam int gate_en_pos     = 3;
  localparam int second_nibble   = 4;

  // field positions in the run/flag register
  localparam int first_run_pos   = 4;
  localparam int first_ovf_pos   = 5;
  localparam int second_run_pos  = 6;
  localparam int second_ovf_pos  = 7;

  // reset values
  localparam logic [7:0] mode_config_reset = 8'h00;
  localparam logic [7:0] run_flag_reset    = 8'h00;
  localparam logic [7:0] count_reset       = 8'h00;

  // machine cycle: 12 oscillator periods
  localparam int          osc_per_machine = 12;
  localparam logic [3:0]  prescale_last   = 4'(osc_per_machine - 1);

  // mode encodings
  typedef enum logic [1:0]
  {
    mode_13bit  = 2'b00,
    mode_16bit  = 2'b01,
    mode_reload = 2'b10,
    mode_split  = 2'b11
  } timer_mode_t;
endpackage

// ===== src/fall_detect.sv
// module: synchronises a count pin and flags a falling edge on the machine-cycle strobe
`timescale 1ns/10ps
module fall_detect
  import timer_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic machine_tick,
  input  wire logic pin,
  output logic      fall
);
  typedef struct packed
  {
    logic meta;
    logic sync;
    logic last_sample;
    logic prev_sample;
  } fd_state_t;

  fd_state_t state;
  fd_state_t next_state;

  ////////////////////////////////////////////////////////////////////
  // two-stage sync, then sample once per machine cycle
  always_comb
  begin
    next_state      = state;
    next_state.meta = pin;
    next_state.sync = state.meta;
    if (machine_tick)
    begin
      // two successive samples: edge seen one cycle after the low sample
      next_state.last_sample = state.sync;
      next_state.prev_sample = state.last_sample;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= '0;
    else
      state <= next_state;
  end

  // high then low across two machine cycles is one count
  assign fall = state.prev_sample & ~state.last_sample;
endmodule

// ===== src/dual_timer_counter_unit.sv
// module: two 16-bit timer/counters with four modes behind an ahb-lite slave
// Operation
// - timer mode counts once per machine cycle
// - counter mode counts count-pin falling edges
// - edge recognition takes two machine cycles
// - mode 0: 13-bit, high byte plus five
// - setting run bit keeps the count bytes
// - rollover to zero sets overflow flag
// - mode 1: full 16-bit counter
// - mode 2: low byte reloads from high
// - mode 3 splits first unit in two
// - second unit mode 3 stops and holds
// - low nibble first unit, high second
// - nibble: mode bits, select, gate
// - select one counts pins, zero cycles
// - gate: count only while gate pin high
// - mode bits decode 13,16,reload,split
// - cleared run bit stops the unit
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module dual_timer_counter_unit
  import timer_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        first_count_pin,
  input  wire logic        second_count_pin,
  input  wire logic        first_gate_pin,
  input  wire logic        second_gate_pin
);
  typedef struct packed
  {
    logic [3:0]  prescale;
    logic        machine_tick;
    logic        gate0_meta;
    logic        gate0_sync;
    logic        gate1_meta;
    logic        gate1_sync;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [7:0]  timer_mode_config;
    logic        first_run_control;
    logic        second_run_control;
    logic        first_overflow_flag;
    logic        second_overflow_flag;
    logic [3:0]  ext_int_bits;
    logic [7:0]  first_timer_low_byte;
    logic [7:0]  first_timer_high_byte;
    logic [7:0]  second_timer_low_byte;
    logic [7:0]  second_timer_high_byte;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic       first_fall;
  logic       second_fall;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // one enable for a unit given its nibble, run bit, gate pin and edge
  function automatic logic unit_advance(input logic [3:0] nib, input logic run,
                                        input logic gate, input logic fall,
                                        input logic tick);
    logic src;
    src = nib[counter_sel_pos] ? fall : tick;
    unit_advance = src & run & (~nib[gate_en_pos] | gate);
  endfunction

  // read view of the run/flag register
  function automatic logic [7:0] run_flag_view(input top_state_t s);
    logic [7:0] v;
    v = {s.second_overflow_flag, s.second_run_control,
         s.first_overflow_flag, s.first_run_control, s.ext_int_bits};
    run_flag_view = v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // edge detectors on the count pins; each holds its own two-flop sync
  fall_detect first_edge
  (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .machine_tick (state.machine_tick),
    .pin          (first_count_pin),
    .fall         (first_fall)
  );

  fall_detect second_edge
  (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .machine_tick (state.machine_tick),
    .pin          (second_count_pin),
    .fall         (second_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // next-state logic: prescaler, counting, bus writes and reads
  always_comb
  begin
    logic [3:0]  nib0;
    logic [3:0]  nib1;
    logic        tick;
    logic        adv0;
    logic        adv1;
    logic        fall0;
    logic        fall1;
    logic [8:0]  sum8;
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic        set_ovf0;
    logic        set_ovf1;
    logic [7:0]  wd;
    logic        rd_take;
    nib0     = '0;
    nib1     = '0;
    tick     = 1'b0;
    adv0     = 1'b0;
    adv1     = 1'b0;
    fall0    = 1'b0;
    fall1    = 1'b0;
    sum8     = '0;
    sum13    = '0;
    sum16    = '0;
    set_ovf0 = 1'b0;
    set_ovf1 = 1'b0;
    wd       = hwdata[7:0];
    rd_take  = 1'b0;
    next_state = state;

    // divide by twelve into a one-cycle strobe
    if (state.prescale == prescale_last)
      next_state.prescale = '0;
    else
      next_state.prescale = state.prescale + 4'h1;
    next_state.machine_tick = (state.prescale == prescale_last);
    tick = state.machine_tick;

    // gate pins cross into the clock domain
    next_state.gate0_meta = first_gate_pin;
    next_state.gate0_sync = state.gate0_meta;
    next_state.gate1_meta = second_gate_pin;
    next_state.gate1_sync = state.gate1_meta;

    // edges only count on the strobe; the detectors sample on it too
    fall0 = first_fall & tick;
    fall1 = second_fall & tick;

    nib0 = state.timer_mode_config[3:0];
    nib1 = state.timer_mode_config[7:second_nibble];

    // first unit, low part always follows its own nibble
    adv0 = unit_advance(nib0, state.first_run_control, state.gate0_sync, fall0, tick);
    // second unit
    adv1 = unit_advance(nib1, state.second_run_control, state.gate1_sync, fall1, tick);

    // first unit by mode
    case (timer_mode_t'(nib0[mode_msb_pos:mode_lsb_pos]))
      mode_13bit:
      begin
        if (adv0)
        begin
          // upper three low bits are left as they were
          sum13 = {1'b0, state.first_timer_high_byte,
                   state.first_timer_low_byte[4:0]} + 14'h0001;
          next_state.first_timer_high_byte     = sum13[12:5];
          next_state.first_timer_low_byte[4:0] = sum13[4:0];
          set_ovf0 = sum13[13];
        end
      end
      mode_16bit:
      begin
        if (adv0)
        begin
          sum16 = {1'b0, state.first_timer_high_byte,
                   state.first_timer_low_byte} + 17'h00001;
          next_state.first_timer_high_byte = sum16[15:8];
          next_state.first_timer_low_byte  = sum16[7:0];
          set_ovf0 = sum16[16];
        end
      end
      mode_reload:
      begin
        if (adv0)
        begin
          sum8 = {1'b0, state.first_timer_low_byte} + 9'h001;
          next_state.first_timer_low_byte = sum8[8] ? state.first_timer_high_byte
                                                    : sum8[7:0];
          set_ovf0 = sum8[8];
        end
      end
      default:
      begin
        // split: low byte on first controls, high byte on second run bit
        if (adv0)
        begin
          sum8 = {1'b0, state.first_timer_low_byte} + 9'h001;
          next_state.first_timer_low_byte = sum8[7:0];
          set_ovf0 = sum8[8];
        end
        if (tick & state.second_run_control)
        begin
          next_state.first_timer_high_byte = state.first_timer_high_byte + 8'h01;
          set_ovf1 = (state.first_timer_high_byte == 8'hff);
        end
      end
    endcase

    // second unit by mode
    case (timer_mode_t'(nib1[mode_msb_pos:mode_lsb_pos]))
      mode_13bit:
      begin
        if (adv1)
        begin
          sum13 = {1'b0, state.second_timer_high_byte,
                   state.second_timer_low_byte[4:0]} + 14'h0001;
          next_state.second_timer_high_byte     = sum13[12:5];
          next_state.second_timer_low_byte[4:0] = sum13[4:0];
          set_ovf1 = set_ovf1 | sum13[13];
        end
      end
      mode_16bit:
      begin
        if (adv1)
        begin
          sum16 = {1'b0, state.second_timer_high_byte,
                   state.second_timer_low_byte} + 17'h00001;
          next_state.second_timer_high_byte = sum16[15:8];
          next_state.second_timer_low_byte  = sum16[7:0];
          set_ovf1 = set_ovf1 | sum16[16];
        end
      end
      mode_reload:
      begin
        if (adv1)
        begin
          sum8 = {1'b0, state.second_timer_low_byte} + 9'h001;
          next_state.second_timer_low_byte = sum8[8] ? state.second_timer_high_byte
                                                     : sum8[7:0];
          set_ovf1 = set_ovf1 | sum8[8];
        end
      end
      default:
      begin
        // stopped: count held as is
        next_state.second_timer_low_byte  = state.second_timer_low_byte;
        next_state.second_timer_high_byte = state.second_timer_high_byte;
      end
    endcase

    // bus write lands one cycle after its address phase
    if (state.wr_pend)
    begin
      case (state.wr_addr)
        addr_mode_config: next_state.timer_mode_config = wd;
        addr_run_flag:
        begin
          // run bits stored only; counts untouched
          next_state.first_run_control    = wd[first_run_pos];
          next_state.second_run_control   = wd[second_run_pos];
          next_state.first_overflow_flag  = wd[first_ovf_pos];
          next_state.second_overflow_flag = wd[second_ovf_pos];
          next_state.ext_int_bits         = wd[3:0];
        end
        addr_first_low:   next_state.first_timer_low_byte   = wd;
        addr_first_high:  next_state.first_timer_high_byte  = wd;
        addr_second_low:  next_state.second_timer_low_byte  = wd;
        addr_second_high: next_state.second_timer_high_byte = wd;
        default:          next_state.wr_addr = state.wr_addr;
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (set_ovf0)
      next_state.first_overflow_flag = 1'b1;
    if (set_ovf1)
      next_state.second_overflow_flag = 1'b1;

    // address phase: latch writes, capture read data
    rd_take = hsel & hready & htrans[1];
    next_state.wr_pend = rd_take & hwrite;
    if (rd_take)
      next_state.wr_addr = haddr[7:0];
    if (rd_take & ~hwrite)
    begin
      case (haddr[7:0])
        addr_mode_config: next_state.rdata = {24'h000000, state.timer_mode_config};
        addr_run_flag:    next_state.rdata = {24'h000000, run_flag_view(state)};
        addr_first_low:   next_state.rdata = {24'h000000, state.first_timer_low_byte};
        addr_first_high:  next_state.rdata = {24'h000000, state.first_timer_high_byte};
        addr_second_low:  next_state.rdata = {24'h000000, state.second_timer_low_byte};
        addr_second_high: next_state.rdata = {24'h000000, state.second_timer_high_byte};
        default:          next_state.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single register stage for all state
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state                   <= '0;
      state.timer_mode_config <= mode_config_reset;
      state.first_timer_low_byte   <= count_reset;
      state.first_timer_high_byte  <= count_reset;
      state.second_timer_low_byte  <= count_reset;
      state.second_timer_high_byte <= count_reset;
    end
    else
      state <= next_state;
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state.rdata;
endmodule

// ===== tb/dual_timer_counter_unit_chk.sv
// checker: bus readback, hold and sticky-flag properties of the dual timer
`timescale 1ns/10ps
module dual_timer_counter_unit_chk
  import timer_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  logic [7:0] mode_sh, run_sh, last_q;
  logic [7:0] last [6];
  logic [5:0] clean;
  logic       dp, wr_q, hit_q, cln_q;
  logic [2:0] idx_q;
  wire ap    = hsel && hready && htrans[1];
  wire hit   = haddr[7:0] < 8'h18 && haddr[1:0] == 2'b00;
  wire rd_dp = dp && !wr_q && hit_q;
  // shadow of software-owned bits; any write inside the register map spoils the hold comparison
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_sh <= 8'h00;
      run_sh  <= 8'h00;
      clean   <= 6'h00;
      dp      <= 1'b0;
    end
    else
    begin
      dp <= ap;
      if (ap)
      begin
        wr_q   <= hwrite;
        hit_q  <= hit;
        idx_q  <= haddr[4:2];
        cln_q  <= hit && clean[haddr[4:2]];
        last_q <= last[haddr[4:2]];
      end
      if (dp && wr_q && hit_q)
      begin
        clean <= 6'h00;
        if (idx_q == 3'd0) mode_sh <= hwdata[7:0];
        if (idx_q == 3'd1) run_sh <= hwdata[7:0];
      end
      if (rd_dp)
      begin
        last[idx_q]  <= hrdata[7:0];
        clean[idx_q] <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////
  chk_reset_zero: assert property ($past(sys_rst) |-> hrdata == 32'h0)
    else $error("read data not zero after reset");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_upper_zero: assert property (ap && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_mode_readback: assert property (ap && !hwrite && haddr[7:0] == addr_mode_config
    |=> hrdata[7:0] == $past(mode_sh)) else $error("mode register readback differs");
  chk_run_readback: assert property (ap && !hwrite && haddr[7:0] == addr_run_flag
    |=> (hrdata[7:0] & 8'h5f) == ($past(run_sh) & 8'h5f)) else $error("run bits differ");
  chk_first_stop: assert property (rd_dp && cln_q && idx_q == 3'd2 && !$past(run_sh[4])
    |-> hrdata[7:0] == last_q) else $error("stopped first unit moved");
  chk_second_hold: assert property (rd_dp && cln_q && idx_q[2]
    && $past(mode_sh[5:4]) == 2'b11 |-> hrdata[7:0] == last_q)
    else $error("second unit in mode three moved");
  chk_flag_sticky: assert property (rd_dp && cln_q && idx_q == 3'd1
    |-> (hrdata[7:0] & last_q & 8'ha0) == (last_q & 8'ha0)) else $error("flag cleared");
  cover property (rd_dp && cln_q && idx_q == 3'd2 && !$past(run_sh[4]));
  cover property (rd_dp && cln_q && idx_q[2] && $past(mode_sh[5:4]) == 2'b11);
  cover property (rd_dp && cln_q && idx_q == 3'd1 && last_q[5]);
endmodule

bind dual_timer_counter_unit dual_timer_counter_unit_chk dual_timer_counter_unit_chk_i
(
  .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp
);

// ===== tb/count_gate_source.sv
// partner: outside world driving the count and gate pins
`timescale 1ns/10ps
module count_gate_source
(
  input  wire logic core_clk,
  output logic      first_count_pin,
  output logic      second_count_pin,
  output logic      first_gate_pin,
  output logic      second_gate_pin
);
  // pins idle high, as the pull-ups leave them
  initial
  begin
    first_count_pin  = 1'b1;
    second_count_pin = 1'b1;
    first_gate_pin   = 1'b1;
    second_gate_pin  = 1'b1;
  end
  // each level stands 24 clocks, twice the minimum, for margin
  task automatic fall_train(input int which, input int n);
    for (int i = 0; i < 2 * n; i++)
    begin
      @(posedge core_clk);
      if (which == 0) first_count_pin <= i[0];
      else second_count_pin <= i[0];
      repeat (23) @(posedge core_clk);
    end
  endtask
  // both gates move together at one edge
  task automatic gates(input logic v);
    @(posedge core_clk);
    first_gate_pin  <= v;
    second_gate_pin <= v;
  endtask
endmodule

// ===== tb/test_dual_timer_counter_unit.sv
// testbench: register access, modes, counting and gating of the dual timer
`timescale 1ns/10ps
module test_dual_timer_counter_unit
  import timer_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'b00;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata, fl;
  logic        hreadyout, hresp;
  logic        first_count_pin, second_count_pin, first_gate_pin, second_gate_pin;
  int          err_count  = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  always #25 core_clk = ~core_clk;
  dual_timer_counter_unit dual_timer_counter_unit_i
  (
    .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .first_count_pin, .second_count_pin, .first_gate_pin, .second_gate_pin
  );
  count_gate_source count_gate_source_i
  (
    .core_clk, .first_count_pin, .second_count_pin, .first_gate_pin, .second_gate_pin
  );
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hung handshake or counter ends the run here
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      give_verdict;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single ahb-lite word transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x & {24'hffffff, m}, {24'h0, e & m});
  endtask
  task automatic load(input logic [7:0] md, h0, l0, h1, l1);
    wr(addr_run_flag, 8'h00);
    wr(addr_mode_config, md);
    wr(addr_first_high, h0);
    wr(addr_first_low, l0);
    wr(addr_second_high, h1);
    wr(addr_second_low, l1);
  endtask
  // run window of exactly 12*k clocks between the two landing writes
  task automatic run_for(input logic [7:0] rb, input int k);
    wr(addr_run_flag, rb);
    repeat (12 * k - 6) @(posedge core_clk);
    bus(1'b0, addr_run_flag, 32'h0, fl);
    // stop both units but write the flags back, so a sticky flag survives the stop
    wr(addr_run_flag, fl[7:0] & 8'haf);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    for (int a = 0; a <= 24; a += 4) rd_chk(8'(a), 8'h00);
    wr(8'h18, 8'hff);
    rd_chk(8'h18, 8'h00);
    wr(addr_mode_config, 8'ha5);
    rd_chk(addr_mode_config, 8'ha5);
    wr(addr_run_flag, 8'h0f);
    rd_chk(addr_run_flag, 8'h0f);
  endtask
  task automatic t_timer;
    load(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
    run_for(8'h10, 20);
    rd_chk(addr_first_low, 8'd20);
    repeat (30) @(posedge core_clk);
    rd_chk(addr_first_low, 8'd20);
    run_for(8'h10, 10);
    rd_chk(addr_first_low, 8'd30);
  endtask
  task automatic t_modes;
    load(8'h01, 8'hff, 8'hf0, 8'h00, 8'h00);
    run_for(8'h10, 20);
    check(fl, 32'h30);
    rd_chk(addr_first_low, 8'h04);
    rd_chk(addr_first_high, 8'h00);
    rd_chk(addr_run_flag, 8'h20);
    rd_chk(addr_run_flag, 8'h20);
    wr(addr_run_flag, 8'h00);
    rd_chk(addr_run_flag, 8'h00);
    // first unit in 13-bit mode, second unit in auto-reload mode
    load(8'h20, 8'hff, 8'h1f, 8'hf0, 8'hfe);
    run_for(8'h50, 12);
    check(fl, 32'hf0);
    rd_chk(addr_first_low, 8'h0b, 8'h1f);
    rd_chk(addr_first_high, 8'h00);
    rd_chk(addr_second_low, 8'hfa);
    rd_chk(addr_second_high, 8'hf0);
    // and the other way round
    load(8'h02, 8'hf0, 8'hfe, 8'hff, 8'h1f);
    run_for(8'h50, 12);
    check(fl, 32'hf0);
    rd_chk(addr_first_low, 8'hfa);
    rd_chk(addr_first_high, 8'hf0);
    rd_chk(addr_second_low, 8'h0b, 8'h1f);
    rd_chk(addr_second_high, 8'h00);
  endtask
  task automatic t_split;
    load(8'h33, 8'hf8, 8'h00, 8'h22, 8'h55);
    run_for(8'h50, 12);
    check(fl, 32'hd0);
    rd_chk(addr_first_low, 8'h0c);
    rd_chk(addr_first_high, 8'h04);
    rd_chk(addr_second_low, 8'h55);
    rd_chk(addr_second_high, 8'h22);
    rd_chk(addr_second_low, 8'h55);
  endtask
  task automatic t_pins;
    load(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(addr_run_flag, 8'h50);
    count_gate_source_i.fall_train(0, 5);
    count_gate_source_i.fall_train(1, 3);
    repeat (48) @(posedge core_clk);
    wr(addr_run_flag, 8'h00);
    rd_chk(addr_first_low, 8'd5);
    rd_chk(addr_second_low, 8'd3);
    load(8'h99, 8'h00, 8'h00, 8'h00, 8'h00);
    count_gate_source_i.gates(1'b0);
    wr(addr_run_flag, 8'h50);
    repeat (240) @(posedge core_clk);
    count_gate_source_i.gates(1'b1);
    repeat (239) @(posedge core_clk);
    count_gate_source_i.gates(1'b0);
    repeat (48) @(posedge core_clk);
    wr(addr_run_flag, 8'h00);
    rd_chk(addr_first_low, 8'd20);
    rd_chk(addr_second_low, 8'd20);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_timer;
    t_modes;
    t_split;
    t_pins;
    give_verdict;
  end
endmodule
